// *** smbci_checker.sv ***
// smbci_checker.sv: protocol checks on the two-wire link wires.
// assumes one pclk domain, async active-low reset, pulled-up lines.
`timescale 1ns/1ps
`default_nettype none
module smbci_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic scl_oe,
	input wire logic sda_host_oe,
	input wire logic sda_dev_oe,
	input wire logic alert_n,
	input wire logic serial_clock_pin,
	input wire logic serial_data_pin
);
	// ----------------------------------------
	// bit position tracking
	// ----------------------------------------
	logic scl_q;
	logic sda_q;
	logic first_q;
	logic rd_q;
	logic [3:0] bitc_q;
	wire scl_rise = serial_clock_pin & ~scl_q;
	wire scl_fall = ~serial_clock_pin & scl_q;
	wire start_w = scl_q & serial_clock_pin & sda_q & ~serial_data_pin;
	wire stop_w = scl_q & serial_clock_pin & ~sda_q & serial_data_pin;
	// raw pins suffice: only the host end drives the clock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			bitc_q <= 4'h0;
			first_q <= 1'b0;
			rd_q <= 1'b0;
		end
		else
		begin
			scl_q <= serial_clock_pin;
			sda_q <= serial_data_pin;
			if (start_w)
			begin
				bitc_q <= 4'h0;
				first_q <= 1'b1;
			end
			else if (scl_rise)
			begin
				bitc_q <= (bitc_q == 4'h9) ? 4'h1 : bitc_q + 4'h1;
				if (first_q && bitc_q == 4'h9)
					first_q <= 1'b0;
				if (first_q && bitc_q == 4'h7)
					rd_q <= serial_data_pin;
			end
		end
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	no_stretch_a: assert property (
		!serial_clock_pin |-> scl_oe) else $error("clock low not host");
	dev_stable_a: assert property (
		serial_clock_pin && scl_q |-> $stable(sda_dev_oe))
		else $error("client data moved with clock high");
	start_quiet_a: assert property (
		start_w |-> !sda_dev_oe [*8]) else $error("client drives at start");
	stop_release_a: assert property (
		stop_w |=> !sda_dev_oe [*8]) else $error("client drives after stop");
	addr_quiet_a: assert property (
		first_q && bitc_q < 4'h8 |-> !sda_dev_oe)
		else $error("client drives in address byte");
	write_slot_a: assert property (
		!first_q && !rd_q && sda_dev_oe |-> bitc_q >= 4'h8)
		else $error("client drives outside ack slot");
	ack_release_a: assert property (
		scl_fall && bitc_q == 4'h9 && !rd_q |-> ##[1:8] !sda_dev_oe)
		else $error("ack held too long");
	read_release_a: assert property (
		scl_rise && !first_q && rd_q && bitc_q == 4'h8 |-> !sda_dev_oe)
		else $error("client blocks host ack slot");
endmodule : smbci_checker
`default_nettype wire

// *** smbci_client.sv ***
// smbci_client.sv: client end of the two-wire link, with register port.
// assumes an external register file read combinationally by reg_index.
// Overview of operation
// (R01) start: data falls while clock high
// (R02) never stretch clock; tolerate stretching
// (R03) address byte: seven bits plus direction
// (R04) own address from sixteen strap codes
// (R05) bytes are eight bits, msb first
// (R06) ack data, own address, ara alerting
// (R07) host nacks last read byte
// (R08) stop resets client state machine
// (R09) optional 30 ms clock-low timeout
// (R10) optional 150 us idle-high reset
// (R11) host clocks at least 10 kHz
// (R12) write byte stores at index
// (R13) read byte after index write
// (R14) index-only write loads pointer
// (R15) receive byte reads pointer register
// (R16) block write to contiguous registers
// (R17) block read from contiguous registers
// (R18) ara read returns own address
// (R19) ara bits checked for contention
// (R20) full ara reply sets mask
// (R21) pointer advances after each data byte
// (R22) inputs synchronised and deglitched
`include "smbci_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module smbci_client #(
	parameter int unsigned TOUT_CYC = `SMBCI_TOUT_CYC,
	parameter int unsigned IDLE_CYC = `SMBCI_IDLE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	smbci_if.dev bus,
	input wire logic [3:0] addr_strap,
	input wire logic timeout_en,
	input wire logic idle_reset_en,
	input wire logic alert_req,
	output logic alert_mask,
	input wire logic mask_clear,
	output logic [7:0] reg_index,
	output logic [7:0] reg_wdata,
	output logic reg_we,
	input wire logic [7:0] reg_rdata
);
	// ----------------------------------------
	// input conditioning
	// ----------------------------------------
	logic [1:0] scl_s_q, sda_s_q;
	logic [1:0] scl_f_q, sda_f_q;
	logic scl_q, sda_q, scl_prev_q, sda_prev_q;
	// (R22) two-flop sync, then deglitch
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			scl_s_q <= 2'h3;
			sda_s_q <= 2'h3;
			scl_f_q <= 2'h3;
			sda_f_q <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end
		else
		begin
			scl_s_q <= {scl_s_q[0], bus.serial_clock_pin};
			sda_s_q <= {sda_s_q[0], bus.serial_data_pin};
			scl_f_q <= {scl_f_q[0], scl_s_q[1]};
			sda_f_q <= {sda_f_q[0], sda_s_q[1]};
			if (scl_f_q == 2'h3)
				scl_q <= 1'b1;
			else if (scl_f_q == 2'h0)
				scl_q <= 1'b0;
			if (sda_f_q == 2'h3)
				sda_q <= 1'b1;
			else if (sda_f_q == 2'h0)
				sda_q <= 1'b0;
			scl_prev_q <= scl_q;
			sda_prev_q <= sda_q;
		end
	end
	wire scl_rise = scl_q & ~scl_prev_q;
	wire scl_fall = ~scl_q & scl_prev_q;
	// (R01) start detect
	wire start_det = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
	// (R08) stop detect
	wire stop_det = scl_q & scl_prev_q & ~sda_prev_q & sda_q;
	// ----------------------------------------
	// own address
	// ----------------------------------------
	logic [6:0] own_addr;
	// (R04) strap code 15 is the open pin
	always_comb
	begin
		unique case (addr_strap)
			4'h0: own_addr = 7'h4c;
			4'h1: own_addr = 7'h4d;
			4'h2: own_addr = 7'h4e;
			4'h3: own_addr = 7'h4f;
			4'h4: own_addr = 7'h48;
			4'h5: own_addr = 7'h49;
			4'h6: own_addr = 7'h4a;
			4'h7: own_addr = 7'h4b;
			4'h8: own_addr = 7'h28;
			4'h9: own_addr = 7'h29;
			4'ha: own_addr = 7'h2a;
			4'hb: own_addr = 7'h2b;
			4'hc: own_addr = 7'h2c;
			4'hd: own_addr = 7'h2c;
			4'he: own_addr = 7'h2d;
			default: own_addr = `SMBCI_OPEN_ADDR;
		endcase
	end
	// ----------------------------------------
	// timeouts
	// ----------------------------------------
	logic [19:0] low_cnt_q;
	logic [12:0] idle_cnt_q;
	// (R09) clock low too long
	wire tout_hit = timeout_en & (low_cnt_q >= 20'(TOUT_CYC));
	// (R10) both lines high too long
	// gated by the live levels so a start edge is never swallowed
	wire idle_hit = idle_reset_en & scl_q & sda_q &
		(idle_cnt_q >= 13'(IDLE_CYC));
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			low_cnt_q <= 20'h0;
			idle_cnt_q <= 13'h0;
		end
		else
		begin
			low_cnt_q <= scl_q ? 20'h0 : (tout_hit ? low_cnt_q : low_cnt_q + 20'h1);
			idle_cnt_q <= !(scl_q && sda_q) ? 13'h0 :
				(idle_hit ? idle_cnt_q : idle_cnt_q + 13'h1);
		end
	end
	// ----------------------------------------
	// client state machine
	// ----------------------------------------
	smbci_pkg::smbci_cst_t st_q;
	logic [7:0] sh_q;
	logic [2:0] bit_q;
	logic [1:0] byte_q;
	logic rd_q, ara_q, ack_ok_q, lost_q, drive_q, first_q;
	logic [7:0] txbyte;
	// (R18) ara reply is own address, lsb one
	assign txbyte = ara_q ? {own_addr, 1'b1} : reg_rdata;
	wire [6:0] rx_addr = sh_q[7:1];
	wire addr_me = (rx_addr == own_addr);
	wire addr_ara = (rx_addr == `SMBCI_ARA_ADDR) & ~alert_mask & alert_req;
	wire abort = stop_det | tout_hit | idle_hit;
	assign bus.alert_n = ~(alert_req & ~alert_mask);
	// (R02) only data is driven, clock never held
	assign bus.sda_dev_oe = drive_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q <= smbci_pkg::SMBCI_C_IDLE;
			sh_q <= 8'h0;
			bit_q <= 3'h0;
			byte_q <= 2'h0;
			rd_q <= 1'b0;
			ara_q <= 1'b0;
			ack_ok_q <= 1'b0;
			lost_q <= 1'b0;
			drive_q <= 1'b0;
			first_q <= 1'b0;
			reg_index <= 8'h0;
			reg_wdata <= 8'h0;
			reg_we <= 1'b0;
			alert_mask <= 1'b0;
		end
		else
		begin
			reg_we <= 1'b0;
			if (mask_clear)
				alert_mask <= 1'b0;
			if (abort)
			begin
				st_q <= smbci_pkg::SMBCI_C_IDLE;
				drive_q <= 1'b0;
			end
			else if (start_det)
			begin
				st_q <= smbci_pkg::SMBCI_C_RX;
				bit_q <= 3'h0;
				byte_q <= 2'h0;
				drive_q <= 1'b0;
				ara_q <= 1'b0;
				// first clock fall after start is not a byte end
				first_q <= 1'b1;
			end
			else
			begin
				unique case (st_q)
					smbci_pkg::SMBCI_C_IDLE:
						drive_q <= 1'b0;
					// (R05) msb first shift in
					smbci_pkg::SMBCI_C_RX:
					begin
						if (scl_rise)
						begin
							sh_q <= {sh_q[6:0], sda_q};
							bit_q <= bit_q + 3'h1;
						end
						else if (scl_fall && bit_q == 3'h0 && first_q)
							first_q <= 1'b0;
						if (scl_fall && bit_q == 3'h0 && !first_q)
						begin
							// (R06) ack decision after eighth bit
							if (byte_q == 2'h0)
							begin
								// (R03) address and direction
								rd_q <= sh_q[0];
								ara_q <= addr_ara & sh_q[0];
								ack_ok_q <= addr_me | (addr_ara & sh_q[0]);
								drive_q <= addr_me | (addr_ara & sh_q[0]);
							end
							else
							begin
								ack_ok_q <= 1'b1;
								drive_q <= 1'b1;
								if (byte_q == 2'h1)
									// (R14) index byte loads pointer only
									reg_index <= sh_q;
								else
								begin
									// (R12) (R16) store data at pointer
									reg_wdata <= sh_q;
									reg_we <= 1'b1;
								end
							end
							st_q <= smbci_pkg::SMBCI_C_ACK;
						end
					end
					smbci_pkg::SMBCI_C_ACK:
						if (scl_fall)
						begin
							drive_q <= 1'b0;
							if (!ack_ok_q)
								st_q <= smbci_pkg::SMBCI_C_IDLE;
							else if (byte_q == 2'h0 && rd_q)
							begin
								// (R13) (R15) first read byte from pointer
								sh_q <= txbyte;
								drive_q <= ~txbyte[7];
								lost_q <= 1'b0;
								st_q <= smbci_pkg::SMBCI_C_TX;
							end
							else
							begin
								// (R21) advance after a stored byte
								if (byte_q == 2'h2)
									reg_index <= reg_index + 8'h1;
								byte_q <= (byte_q == 2'h0) ? 2'h1 : 2'h2;
								st_q <= smbci_pkg::SMBCI_C_RX;
							end
						end
					smbci_pkg::SMBCI_C_TX:
					begin
						// (R19) released one sampled low: contention
						if (scl_rise && !drive_q && !sda_q)
						begin
							lost_q <= 1'b1;
							st_q <= smbci_pkg::SMBCI_C_IDLE;
						end
						else if (scl_rise)
							bit_q <= bit_q + 3'h1;
						if (scl_fall && !lost_q)
						begin
							sh_q <= {sh_q[6:0], 1'b0};
							if (bit_q == 3'h0)
							begin
								drive_q <= 1'b0;
								st_q <= smbci_pkg::SMBCI_C_TXACK;
								// (R20) whole reply sent, mask alert
								if (ara_q)
									alert_mask <= 1'b1;
								else
									reg_index <= reg_index + 8'h1;
							end
							else
								drive_q <= ~sh_q[6];
						end
					end
					smbci_pkg::SMBCI_C_TXACK:
					begin
						// (R07) (R17) host nack ends the read
						if (scl_rise)
							ack_ok_q <= ~sda_q & ~ara_q;
						if (scl_fall)
						begin
							if (ack_ok_q)
							begin
								sh_q <= txbyte;
								drive_q <= ~txbyte[7];
								st_q <= smbci_pkg::SMBCI_C_TX;
							end
							else
								st_q <= smbci_pkg::SMBCI_C_IDLE;
						end
					end
					default:
						st_q <= smbci_pkg::SMBCI_C_IDLE;
				endcase
			end
		end
	end
endmodule : smbci_client
`default_nettype wire

// *** smbci_consts.svh ***
// smbci_consts.svh: offsets, address codes and timing counts for the
// two-wire client link. assumes a 20 MHz system clock on both ends.
`ifndef SMBCI_CONSTS_SVH
`define SMBCI_CONSTS_SVH
// ----------------------------------------
// clock and timing
// ----------------------------------------
`define SMBCI_CLK_HZ 20000000
`define SMBCI_TOUT_MS 30
`define SMBCI_TOUT_CYC ((`SMBCI_CLK_HZ / 1000) * `SMBCI_TOUT_MS + 1)
`define SMBCI_IDLE_US 150
`define SMBCI_IDLE_CYC ((`SMBCI_CLK_HZ / 1000000) * `SMBCI_IDLE_US + 1)
`define SMBCI_GLITCH_CYC 2
`define SMBCI_HALF_DIV 50
// ----------------------------------------
// addresses
// ----------------------------------------
`define SMBCI_ARA_ADDR 7'h0c
`define SMBCI_OPEN_ADDR 7'h18
// ----------------------------------------
// host apb register offsets
// ----------------------------------------
`define SMBCI_OFF_CTRL 12'h000
`define SMBCI_OFF_STAT 12'h004
`define SMBCI_OFF_RDATA 12'h008
// ctrl fields
`define SMBCI_CTRL_GO 0
`define SMBCI_CTRL_RD 1
`define SMBCI_CTRL_NOIDX 2
`define SMBCI_CTRL_ADDR_LSB 8
`define SMBCI_CTRL_IDX_LSB 16
`define SMBCI_CTRL_DATA_LSB 24
`define SMBCI_CTRL_CNT_LSB 4
// stat fields
`define SMBCI_STAT_BUSY 0
`define SMBCI_STAT_NAK 1
`endif

// *** smbci_host.sv ***
// smbci_host.sv: host end; apb registers steer one bus transaction.
// assumes pull-ups on both lines and a 20 MHz pclk.
`include "smbci_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module smbci_host #(
	parameter int unsigned HALF_DIV = `SMBCI_HALF_DIV
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	smbci_if.host bus
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [31:0] ctrl_q;
	logic [7:0] rdata_q;
	logic busy_q, nak_q;
	wire wr_en = psel & penable & pwrite;
	wire hit_ctrl = (paddr == `SMBCI_OFF_CTRL);
	wire hit_stat = (paddr == `SMBCI_OFF_STAT);
	wire hit_rd = (paddr == `SMBCI_OFF_RDATA);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~(hit_ctrl | hit_stat | hit_rd);
	assign prdata = hit_ctrl ? ctrl_q :
		hit_stat ? {30'h0, nak_q, busy_q} :
		hit_rd ? {24'h0, rdata_q} : 32'h0;
	wire go = wr_en & hit_ctrl & pwdata[`SMBCI_CTRL_GO] & ~busy_q;
	// ----------------------------------------
	// bit sequencer: a list of bus phases
	// ----------------------------------------
	// one quarter-bit tick from the divider
	logic [7:0] div_q;
	wire tick = (div_q == 8'(HALF_DIV - 1));
	logic [1:0] ph_q;
	logic [3:0] bit_q;
	logic [3:0] seq_q;
	logic [3:0] left_q;
	logic [7:0] tx_q, rx_q;
	logic scl_oe_q, sda_oe_q;
	// seq steps: 0 start,1 addr,2 idx,3 data,4 rstart,5 raddr,6 rd,7 stop
	wire rd_mode = ctrl_q[`SMBCI_CTRL_RD];
	wire noidx = ctrl_q[`SMBCI_CTRL_NOIDX];
	wire [6:0] tgt = ctrl_q[`SMBCI_CTRL_ADDR_LSB +: 7];
	wire last_rd = (left_q == 4'h0);
	wire sda_in = bus.serial_data_pin;
	assign bus.scl_oe = scl_oe_q;
	assign bus.sda_host_oe = sda_oe_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= 32'h0;
			rdata_q <= 8'h0;
			busy_q <= 1'b0;
			nak_q <= 1'b0;
			div_q <= 8'h0;
			ph_q <= 2'h0;
			bit_q <= 4'h0;
			seq_q <= 4'h0;
			left_q <= 4'h0;
			tx_q <= 8'h0;
			rx_q <= 8'h0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end
		else
		begin
			div_q <= tick ? 8'h0 : div_q + 8'h1;
			if (go)
			begin
				ctrl_q <= pwdata;
				busy_q <= 1'b1;
				nak_q <= 1'b0;
				left_q <= pwdata[`SMBCI_CTRL_CNT_LSB +: 4];
				seq_q <= 4'h0;
				ph_q <= 2'h0;
			end
			else if (wr_en && hit_ctrl)
				ctrl_q <= pwdata;
			if (busy_q && tick)
			begin
				ph_q <= ph_q + 2'h1;
				if (seq_q == 4'h0 || seq_q == 4'h4)
				begin
					// (R01) data falls with clock high
					unique case (ph_q)
						2'h0: begin sda_oe_q <= 1'b0; scl_oe_q <= 1'b0; end
						2'h1: sda_oe_q <= 1'b1;
						2'h2: scl_oe_q <= 1'b1;
						default:
						begin
							bit_q <= 4'h0;
							// (R03) address then direction
							tx_q <= {tgt, (seq_q == 4'h4) | (rd_mode & noidx)};
							seq_q <= (seq_q == 4'h4) ? 4'h5 : 4'h1;
						end
					endcase
				end
				else if (seq_q == 4'h7)
				begin
					// (R08) data rises with clock high
					unique case (ph_q)
						2'h0: begin scl_oe_q <= 1'b1; sda_oe_q <= 1'b1; end
						2'h1: scl_oe_q <= 1'b0;
						2'h2: sda_oe_q <= 1'b0;
						default: busy_q <= 1'b0;
					endcase
				end
				else
				begin
					// (R05) msb first, ninth bit is ack
					unique case (ph_q)
						2'h0: sda_oe_q <= (bit_q == 4'h8) ?
							(seq_q == 4'h6 && !last_rd) :
							(seq_q != 4'h6) & ~tx_q[7];
						2'h1: scl_oe_q <= 1'b0;
						2'h2:
						begin
							// (R02) wait out a stretched clock
							if (!bus.serial_clock_pin)
								ph_q <= 2'h2;
							else if (bit_q != 4'h8)
								rx_q <= {rx_q[6:0], sda_in};
							else if (seq_q != 4'h6 && sda_in)
								nak_q <= 1'b1;
						end
						default:
						begin
							scl_oe_q <= 1'b1;
							tx_q <= {tx_q[6:0], 1'b0};
							bit_q <= bit_q + 4'h1;
							if (bit_q == 4'h8)
							begin
								bit_q <= 4'h0;
								if (nak_q)
									seq_q <= 4'h7;
								else unique case (seq_q)
									4'h1:
									begin
										seq_q <= (rd_mode && noidx) ? 4'h6 : 4'h2;
										tx_q <= ctrl_q[`SMBCI_CTRL_IDX_LSB +: 8];
									end
									// (R14) index only when writing with count zero
									4'h2:
									begin
										seq_q <= rd_mode ? 4'h4 :
											(left_q == 4'h0 ? 4'h7 : 4'h3);
										tx_q <= ctrl_q[`SMBCI_CTRL_DATA_LSB +: 8];
									end
									// (R12) (R16) data bytes, repeated value
									4'h3:
									begin
										left_q <= left_q - 4'h1;
										seq_q <= (left_q == 4'h1) ? 4'h7 : 4'h3;
										tx_q <= ctrl_q[`SMBCI_CTRL_DATA_LSB +: 8];
									end
									4'h5: seq_q <= 4'h6;
									// (R07) (R17) nack last then stop
									4'h6:
									begin
										rdata_q <= rx_q;
										left_q <= left_q - 4'h1;
										seq_q <= last_rd ? 4'h7 : 4'h6;
									end
									default: seq_q <= 4'h7;
								endcase
							end
						end
					endcase
				end
			end
		end
	end
	// (R11) four ticks per bit, 100 kHz by default
endmodule : smbci_host
`default_nettype wire

// *** smbci_if.sv ***
// smbci_if.sv: open-drain clock and data wires between host and client.
// assumes both lines are pulled up; a driver only ever pulls low.
`timescale 1ns/1ps
`default_nettype none
interface smbci_if;
	logic scl_oe;
	logic sda_host_oe;
	logic sda_dev_oe;
	logic alert_n;
	wire logic serial_clock_pin;
	wire logic serial_data_pin;
	assign serial_clock_pin = ~scl_oe;
	assign serial_data_pin = ~(sda_host_oe | sda_dev_oe);
	modport dev (
		input serial_clock_pin,
		input serial_data_pin,
		output sda_dev_oe,
		output alert_n
	);
	modport host (
		input serial_clock_pin,
		input serial_data_pin,
		input alert_n,
		output scl_oe,
		output sda_host_oe
	);
endinterface : smbci_if
`default_nettype wire

// *** smbci_pkg.sv ***
// smbci_pkg.sv: shared types for the two-wire client link.
// assumes smbci_consts.svh is compiled alongside.
package smbci_pkg;
	typedef enum logic [4:0] {
		SMBCI_C_IDLE = 5'b00001,
		SMBCI_C_RX = 5'b00010,
		SMBCI_C_ACK = 5'b00100,
		SMBCI_C_TX = 5'b01000,
		SMBCI_C_TXACK = 5'b10000
	} smbci_cst_t;
endpackage : smbci_pkg

// *** testbench.sv ***
// testbench.sv: host and client ends joined over the link, apb driven.
// assumes a shared 20 MHz pclk and a register file modelled here.
`include "smbci_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] addr_strap;
	logic timeout_en, idle_reset_en, alert_req, alert_mask, mask_clear;
	logic reg_we;
	logic [7:0] reg_index, reg_wdata, reg_rdata;
	logic [7:0] regs [256];
	int fails, samples_checked;
	localparam logic [6:0] ADDR_TAB [16] = '{7'h4c, 7'h4d, 7'h4e, 7'h4f,
		7'h48, 7'h49, 7'h4a, 7'h4b, 7'h28, 7'h29, 7'h2a, 7'h2b, 7'h2c,
		7'h2c, 7'h2d, 7'h18};
	smbci_if bus_if ();
	// short divider keeps each bit at 32 pclk
	smbci_host #(.HALF_DIV(8)) smbci_host_i (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus(bus_if));
	smbci_client #(.TOUT_CYC(200), .IDLE_CYC(100)) smbci_client_i (
		.pclk(pclk), .presetn(presetn), .bus(bus_if),
		.addr_strap(addr_strap), .timeout_en(timeout_en),
		.idle_reset_en(idle_reset_en), .alert_req(alert_req),
		.alert_mask(alert_mask), .mask_clear(mask_clear),
		.reg_index(reg_index), .reg_wdata(reg_wdata), .reg_we(reg_we),
		.reg_rdata(reg_rdata));
	smbci_checker smbci_checker_i (.pclk(pclk), .presetn(presetn),
		.scl_oe(bus_if.scl_oe), .sda_host_oe(bus_if.sda_host_oe),
		.sda_dev_oe(bus_if.sda_dev_oe), .alert_n(bus_if.alert_n),
		.serial_clock_pin(bus_if.serial_clock_pin),
		.serial_data_pin(bus_if.serial_data_pin));
	assign reg_rdata = regs[reg_index];
	always #25 pclk = ~pclk;
	always @(posedge pclk)
		if (reg_we)
			regs[reg_index] <= reg_wdata;
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic test_done;
		$display("checked %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1 && ++n < 64);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic logic [31:0] mk(logic rd, logic nx, logic [3:0] cnt,
		logic [6:0] a, logic [7:0] idx, logic [7:0] d);
		return {d, idx, 1'b0, a, cnt, 1'b0, nx, rd, 1'b1};
	endfunction : mk
	task automatic xfer(input logic [31:0] c, output logic [31:0] st,
		output logic [31:0] rd);
		logic e;
		int n;
		n = 0;
		apb(1'b1, `SMBCI_OFF_CTRL, c, st, e);
		do
			apb(1'b0, `SMBCI_OFF_STAT, 32'h0, st, e);
		while (st[`SMBCI_STAT_BUSY] !== 1'b0 && ++n < 3000);
		apb(1'b0, `SMBCI_OFF_RDATA, 32'h0, rd, e);
	endtask : xfer
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_straps;
		logic [31:0] st, rd;
		for (int s = 0; s < 16; s++)
		begin
			addr_strap <= s[3:0];
			repeat (4) @(posedge pclk);
			xfer(mk(0, 0, 4'h1, ADDR_TAB[s], 8'h80 + s[7:0], 8'ha0 ^ s[7:0]),
				st, rd);
			chk(st[`SMBCI_STAT_NAK], 0);
			chk(regs[8'h80 + s[7:0]], 8'ha0 ^ s[7:0]);
		end
		$display("done: address straps");
	endtask : t_straps
	task automatic t_write;
		logic [31:0] st, rd;
		timeout_en <= 1'b1;
		idle_reset_en <= 1'b1;
		xfer(mk(0, 0, 4'h3, 7'h18, 8'h20, 8'h96), st, rd);
		chk(st[`SMBCI_STAT_NAK], 0);
		for (int i = 8'h1f; i < 8'h24; i++)
			chk(regs[i], (i > 8'h1f && i < 8'h23) ? 8'h96 : i[7:0] ^ 8'h5a);
		timeout_en <= 1'b0;
		idle_reset_en <= 1'b0;
		$display("done: block write");
	endtask : t_write
	task automatic t_read;
		logic [31:0] st, rd;
		xfer(mk(1, 0, 4'h0, 7'h18, 8'h50, 8'h00), st, rd);
		chk(rd[7:0], 8'h50 ^ 8'h5a);
		xfer(mk(1, 0, 4'h2, 7'h18, 8'h60, 8'h00), st, rd);
		chk(rd[7:0], 8'h62 ^ 8'h5a);
		chk(st[`SMBCI_STAT_NAK], 0);
		$display("done: reads");
	endtask : t_read
	task automatic t_index;
		logic [31:0] st, rd;
		xfer(mk(0, 0, 4'h0, 7'h18, 8'h41, 8'hff), st, rd);
		chk(regs[8'h41], 8'h41 ^ 8'h5a);
		xfer(mk(1, 1, 4'h0, 7'h18, 8'h00, 8'h00), st, rd);
		chk(rd[7:0], 8'h41 ^ 8'h5a);
		xfer(mk(0, 0, 4'h1, 7'h4c, 8'h42, 8'h00), st, rd);
		chk(st[`SMBCI_STAT_NAK], 1);
		chk(regs[8'h42], 8'h42 ^ 8'h5a);
		$display("done: index and foreign address");
	endtask : t_index
	task automatic t_ara;
		logic [31:0] st, rd;
		logic e;
		xfer(mk(1, 1, 4'h0, 7'h0c, 8'h00, 8'h00), st, rd);
		chk(st[`SMBCI_STAT_NAK], 1);
		alert_req <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(bus_if.alert_n, 0);
		xfer(mk(1, 1, 4'h0, 7'h0c, 8'h00, 8'h00), st, rd);
		chk(rd[7:0], 8'h31);
		chk(alert_mask, 1);
		chk(bus_if.alert_n, 1);
		mask_clear <= 1'b1;
		@(posedge pclk);
		mask_clear <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(alert_mask, 0);
		alert_req <= 1'b0;
		// unmapped offset must be refused
		apb(1'b0, 12'h00c, 32'h0, rd, e);
		chk(e, 1);
		$display("done: alert response");
	endtask : t_ara
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		addr_strap = 4'hf;
		timeout_en = 1'b0;
		idle_reset_en = 1'b0;
		alert_req = 1'b0;
		mask_clear = 1'b0;
		fails = 0;
		samples_checked = 0;
		for (int i = 0; i < 256; i++)
			regs[i] = i[7:0] ^ 8'h5a;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_straps;
		t_write;
		t_read;
		t_index;
		t_ara;
		test_done;
	end
	// whole run needs roughly 22k cycles
	initial
	begin
		#(80000 * 50);
		fails++;
		test_done;
	end
endmodule : testbench
`default_nettype wire
